// ===== src/ocv_alu_if.sv
// Purpose: Digit adder port between sequencer and decimal adder
// Assumes: Purely combinational path
// Notes:   sub selects subtract; cout is carry or borrow
`default_nettype none
interface ocv_alu_if;
	logic [3:0] a;
	logic [3:0] b;
	logic       cin;
	logic       sub;
	logic [3:0] res;
	logic       cout;
	modport user (output a, b, cin, sub, input res, cout);
	modport alu (input a, b, cin, sub, output res, cout);
endinterface : ocv_alu_if
`default_nettype wire

// ===== src/ocv_digit_alu.sv
// Purpose: One decimal digit add or subtract with carry
// Assumes: Operand digits are 0 to 9
// Notes:   Borrow is reported on cout when subtracting
`default_nettype none
module ocv_digit_alu (
	ocv_alu_if.alu port
);
	logic [4:0] t;

	always_comb begin
		if (port.sub) begin
			t = {1'b0, port.a} - {1'b0, port.b} - {4'h0, port.cin};
		end else begin
			t = {1'b0, port.a} + {1'b0, port.b} + {4'h0, port.cin};
		end
		if (port.sub && t[4]) begin
			port.res = 4'(t + ocv_pkg::DEC_BASE);
			port.cout = 1'b1;
		end else if (!port.sub && t >= ocv_pkg::DEC_BASE) begin
			port.res = 4'(t - ocv_pkg::DEC_BASE);
			port.cout = 1'b1;
		end else begin
			port.res = t[3:0];
			port.cout = 1'b0;
		end
	end
endmodule : ocv_digit_alu
`default_nettype wire

// ===== src/ocv_field_unit.sv
// Purpose: Octal complement and octal/decimal conversion on digit storage
// Assumes: Storage answers a request on the same edge that samples it
// Notes:   One storage request at a time; fields walk digit by digit
// Function
// - Complement inverts 4, 2, 1 bits
// - Stop on source flag, copy flag
// - 8 bit neither inverted nor copied
// - Complemented digits get correct check bit
// - Zero indicator when result has no bits
// - Source untouched, destination fully overwritten
// - First operand is table units address
// - Table may sit anywhere in storage
// - Second operand is octal units, to flag
// - Multiply digits by entries, sum products
// - Result units at 00099, leftmost flagged
// - Clear 00080 to 00099; software clears lower
// - Quotient digits stored at rising addresses
// - Repeated subtraction counts the quotient digit
// - Eighth successful subtraction sets overflow
// - First quotient digit written is flagged
// - Step to lower entry, stop at mark
`default_nettype none
module ocv_field_unit (
	input  wire logic        ref_clk,
	input  wire logic        reset,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic             memReq,
	output logic             memWe,
	output logic      [15:0] memAddr,
	output logic      [5:0]  memWdata,
	input  wire logic [5:0]  memRdata,
	output logic             zeroInd,
	output logic             ovfInd,
	output logic             busy
);
	ocv_pkg::ocv_core_t s;
	ocv_pkg::ocv_core_t n;
	ocv_alu_if          alu ();
	logic               addPass;

	ocv_digit_alu u_alu (
		.port (alu.alu)
	);

	// Product digit is consumed straight from storage when adding
	assign addPass = s.st == ocv_pkg::ST_OADD;
	assign alu.a   = addPass ? memRdata[3:0] : s.dDig;
	assign alu.b   = s.eDig;
	assign alu.cin = s.carry;
	assign alu.sub = !addPass;

	function automatic ocv_pkg::ocv_core_t rd(
		input ocv_pkg::ocv_core_t c,
		input logic [15:0]        a,
		input ocv_pkg::ocv_st_t   r);
		c.memReq = 1'b1;
		c.memWe = 1'b0;
		c.memAddr = a;
		c.ret = r;
		c.st = ocv_pkg::ST_WAIT;
		return c;
	endfunction : rd

	function automatic ocv_pkg::ocv_core_t wr(
		input ocv_pkg::ocv_core_t c,
		input logic [15:0]        a,
		input logic [5:0]         d);
		c.memReq = 1'b1;
		c.memWe = 1'b1;
		c.memAddr = a;
		c.memWdata = d;
		return c;
	endfunction : wr

	always_comb begin
		logic       go;
		logic [2:0] inv;
		go = 1'b0;
		inv = ~memRdata[2:0];
		n = s;
		n.memReq = 1'b0;
		n.memWe = 1'b0;
		n.ack = 1'b0;
		// Bus slave answers every access one edge later
		if (wb_cyc_i && wb_stb_i && !s.ack) begin
			n.ack = 1'b1;
			n.rdat = 32'h0000_0000;
			if (wb_we_i) begin
				case (wb_adr_i)
					ocv_pkg::REG_CTRL: begin
						go = wb_sel_i[0] && wb_dat_i[ocv_pkg::CTRL_START];
					end
					ocv_pkg::REG_PADDR: begin
						if (wb_sel_i[0]) n.pReg[7:0] = wb_dat_i[7:0];
						if (wb_sel_i[1]) n.pReg[15:8] = wb_dat_i[15:8];
					end
					ocv_pkg::REG_QADDR: begin
						if (wb_sel_i[0]) n.qReg[7:0] = wb_dat_i[7:0];
						if (wb_sel_i[1]) n.qReg[15:8] = wb_dat_i[15:8];
					end
					ocv_pkg::REG_STATUS: begin
						if (wb_sel_i[0] && wb_dat_i[ocv_pkg::STAT_OVF]) begin
							n.ovf = 1'b0;
						end
					end
					default: begin
					end
				endcase
			end else begin
				case (wb_adr_i)
					ocv_pkg::REG_CTRL: n.rdat[1:0] = s.op;
					ocv_pkg::REG_PADDR: n.rdat[15:0] = s.pReg;
					ocv_pkg::REG_QADDR: n.rdat[15:0] = s.qReg;
					ocv_pkg::REG_STATUS: begin
						n.rdat[ocv_pkg::STAT_BUSY] = s.busy;
						n.rdat[ocv_pkg::STAT_ZERO] = s.zeroInd;
						n.rdat[ocv_pkg::STAT_OVF] = s.ovf;
					end
					default: n.rdat = 32'h0000_0000;
				endcase
			end
		end
		case (s.st)
			ocv_pkg::ST_IDLE: begin
				if (go) begin
					n.op = ocv_pkg::ocv_op_t'(wb_dat_i[1:0]);
					n.busy = 1'b1;
					n.qa = s.qReg;
					n.pa = s.pReg;
					n.commit = 1'b0;
					n.first = 1'b1;
					n.cnt = 4'h0;
					n.zeroAcc = 1'b1;
					case (ocv_pkg::ocv_op_t'(wb_dat_i[1:0]))
						ocv_pkg::OCTAL_COMPLEMENT_OP: n.st = ocv_pkg::ST_CPLR;
						ocv_pkg::OCTAL_TO_DECIMAL_OP: begin
							n.ta = s.pReg;
							n.wa = ocv_pkg::PROD_LOW;
							n.minAddr = ocv_pkg::PROD_UNITS;
							n.st = ocv_pkg::ST_OCLR;
						end
						ocv_pkg::DECIMAL_TO_OCTAL_OP: begin
							n.ta = s.qReg;
							n.st = ocv_pkg::ST_DTRY;
						end
						default: n.busy = 1'b0;
					endcase
				end
			end
			ocv_pkg::ST_WAIT: n.st = s.ret;
			ocv_pkg::ST_DONE: begin
				if (s.op == ocv_pkg::OCTAL_COMPLEMENT_OP) n.zeroInd = s.zeroAcc;
				n.busy = 1'b0;
				n.st = ocv_pkg::ST_IDLE;
			end
			ocv_pkg::ST_CPLR: n = rd(n, s.qa, ocv_pkg::ST_CPLW);
			ocv_pkg::ST_CPLW: begin
				n = wr(n, s.pa, ocv_pkg::mkDigit(memRdata[ocv_pkg::FLAG_BIT],
					{1'b0, inv}));
				if (inv != 3'h0) n.zeroAcc = 1'b0;
				if (memRdata[ocv_pkg::FLAG_BIT]) begin
					n.st = ocv_pkg::ST_DONE;
				end else begin
					n.qa = s.qa - 16'h0001;
					n.pa = s.pa - 16'h0001;
					n.st = ocv_pkg::ST_CPLR;
				end
			end
			ocv_pkg::ST_OCLR: begin
				n = wr(n, s.wa, ocv_pkg::mkDigit(1'b0, 4'h0));
				if (s.wa == ocv_pkg::PROD_UNITS) begin
					n.st = ocv_pkg::ST_ORDQ;
				end else begin
					n.wa = s.wa + 16'h0001;
				end
			end
			ocv_pkg::ST_ORDQ: n = rd(n, s.qa, ocv_pkg::ST_OGOTQ);
			ocv_pkg::ST_OGOTQ: begin
				n.cnt = memRdata[3:0];
				n.qLast = memRdata[ocv_pkg::FLAG_BIT];
				n.ea = s.ta;
				n.wa = ocv_pkg::PROD_UNITS;
				n.carry = 1'b0;
				n.eDone = 1'b0;
				if (memRdata[3:0] == 4'h0) begin
					n.st = ocv_pkg::ST_OSCR;
				end else begin
					n.st = ocv_pkg::ST_ORDE;
				end
			end
			ocv_pkg::ST_ORDE: begin
				if (s.eDone) begin
					n.eDig = 4'h0;
					n = rd(n, s.wa, ocv_pkg::ST_OADD);
				end else begin
					n = rd(n, s.ea, ocv_pkg::ST_OGOTE);
				end
			end
			ocv_pkg::ST_OGOTE: begin
				n.eDig = memRdata[3:0];
				n.eDone = memRdata[ocv_pkg::FLAG_BIT];
				n = rd(n, s.wa, ocv_pkg::ST_OADD);
			end
			ocv_pkg::ST_OADD: begin
				n = wr(n, s.wa, ocv_pkg::mkDigit(1'b0, alu.res));
				if (alu.res != 4'h0 && s.wa < s.minAddr) n.minAddr = s.wa;
				n.carry = alu.cout;
				if (s.eDone && !alu.cout) begin
					n.cnt = s.cnt - 4'h1;
					n.ea = s.ta;
					n.wa = ocv_pkg::PROD_UNITS;
					n.carry = 1'b0;
					n.eDone = 1'b0;
					if (s.cnt == 4'h1) begin
						n.st = ocv_pkg::ST_OSCR;
					end else begin
						n.st = ocv_pkg::ST_ORDE;
					end
				end else begin
					n.wa = s.wa - 16'h0001;
					n.ea = s.ea - 16'h0001;
					n.st = ocv_pkg::ST_ORDE;
				end
			end
			ocv_pkg::ST_OSCR: n = rd(n, s.ea, ocv_pkg::ST_OSCG);
			ocv_pkg::ST_OSCG: begin
				// next entry lies left of flag
				if (memRdata[ocv_pkg::FLAG_BIT]) begin
					n.ta = s.ea - 16'h0001;
					if (s.qLast) begin
						n.st = ocv_pkg::ST_FLR;
					end else begin
						n.qa = s.qa - 16'h0001;
						n.st = ocv_pkg::ST_ORDQ;
					end
				end else begin
					n.ea = s.ea - 16'h0001;
					n.st = ocv_pkg::ST_OSCR;
				end
			end
			ocv_pkg::ST_FLR: n = rd(n, s.minAddr, ocv_pkg::ST_FLW);
			ocv_pkg::ST_FLW: begin
				n = wr(n, s.minAddr, ocv_pkg::mkDigit(1'b1, memRdata[3:0]));
				n.st = ocv_pkg::ST_DONE;
			end
			ocv_pkg::ST_DTRY: begin
				n.ea = s.ta;
				n.wa = ocv_pkg::PROD_UNITS;
				n.carry = 1'b0;
				n.eDone = 1'b0;
				n.dDone = 1'b0;
				n.st = ocv_pkg::ST_DRDE;
			end
			ocv_pkg::ST_DRDE: begin
				if (s.eDone) begin
					n.eDig = 4'h0;
					n.st = ocv_pkg::ST_DRDD;
				end else begin
					n = rd(n, s.ea, ocv_pkg::ST_DGOTE);
				end
			end
			ocv_pkg::ST_DGOTE: begin
				n.eDig = memRdata[3:0];
				n.eDone = memRdata[ocv_pkg::FLAG_BIT];
				n.st = ocv_pkg::ST_DRDD;
			end
			ocv_pkg::ST_DRDD: begin
				if (s.dDone) begin
					n.dDig = 4'h0;
					n.dValid = 1'b0;
					n.st = ocv_pkg::ST_DSUB;
				end else begin
					n = rd(n, s.wa, ocv_pkg::ST_DGOTD);
				end
			end
			ocv_pkg::ST_DGOTD: begin
				n.dDig = memRdata[3:0];
				n.dFlag = memRdata[ocv_pkg::FLAG_BIT];
				n.dDone = memRdata[ocv_pkg::FLAG_BIT];
				n.dValid = 1'b1;
				n.st = ocv_pkg::ST_DSUB;
			end
			ocv_pkg::ST_DSUB: begin
				if (s.commit && s.dValid) begin
					n = wr(n, s.wa, ocv_pkg::mkDigit(s.dFlag, alu.res));
				end
				n.carry = alu.cout;
				if (s.eDone && s.dDone) begin
					if (!s.commit) begin
						if (alu.cout) begin
							n.st = ocv_pkg::ST_DQW;
						end else begin
							n.commit = 1'b1;
							n.st = ocv_pkg::ST_DTRY;
						end
					end else begin
						n.commit = 1'b0;
						n.cnt = s.cnt + 4'h1;
						if (s.cnt == ocv_pkg::QUOT_LAST) begin
							n.ovf = 1'b1;
							n.st = ocv_pkg::ST_DQW;
						end else begin
							n.st = ocv_pkg::ST_DTRY;
						end
					end
				end else begin
					n.ea = s.ea - 16'h0001;
					n.wa = s.wa - 16'h0001;
					n.st = ocv_pkg::ST_DRDE;
				end
			end
			ocv_pkg::ST_DQW: begin
				n = wr(n, s.pa, ocv_pkg::mkDigit(s.first, {1'b0, s.cnt[2:0]}));
				n.st = ocv_pkg::ST_DNX1;
			end
			ocv_pkg::ST_DNX1: begin
				n = rd(n, s.ta + 16'h0001, ocv_pkg::ST_DNX2);
			end
			ocv_pkg::ST_DNX2: begin
				if (ocv_pkg::isRecMark(memRdata)) begin
					n.st = ocv_pkg::ST_DONE;
				end else begin
					n.ea = s.ta + 16'h0001;
					n.st = ocv_pkg::ST_DSC1;
				end
			end
			ocv_pkg::ST_DSC1: begin
				n = rd(n, s.ea + 16'h0001, ocv_pkg::ST_DSC2);
			end
			ocv_pkg::ST_DSC2: begin
				if (memRdata[ocv_pkg::FLAG_BIT] || ocv_pkg::isRecMark(memRdata)) begin
					n.ta = s.ea;
					n.pa = s.pa + 16'h0001;
					n.first = 1'b0;
					n.cnt = 4'h0;
					n.commit = 1'b0;
					n.st = ocv_pkg::ST_DTRY;
				end else begin
					n.ea = s.ea + 16'h0001;
					n.st = ocv_pkg::ST_DSC1;
				end
			end
			default: n.st = ocv_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			s <= ocv_pkg::CORE_RESET;
		end else begin
			s <= n;
		end
	end

	assign wb_dat_o = s.rdat;
	assign wb_ack_o = s.ack;
	assign memReq   = s.memReq;
	assign memWe    = s.memWe;
	assign memAddr  = s.memAddr;
	assign memWdata = s.memWdata;
	assign zeroInd  = s.zeroInd;
	assign ovfInd   = s.ovf;
	assign busy     = s.busy;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (reset);

	cpl_invert_a: assert property (
		s.st == ocv_pkg::ST_CPLW |=> s.memWe
			&& s.memWdata[2:0] == ~$past(memRdata[2:0]))
		else $error("complement data wrong");
	cpl_flag_stop_a: assert property (
		s.st == ocv_pkg::ST_CPLW && memRdata[ocv_pkg::FLAG_BIT]
			|=> s.memWdata[ocv_pkg::FLAG_BIT] ##1 !s.busy)
		else $error("complement did not stop on flag");
	cpl_no_eight_a: assert property (
		s.st == ocv_pkg::ST_CPLW |=> !s.memWdata[3])
		else $error("eight bit written");
	write_parity_a: assert property (
		s.memReq && s.memWe |-> ^s.memWdata[4:0])
		else $error("bad check bit");
	zero_ind_a: assert property (
		s.st == ocv_pkg::ST_DONE && s.op == ocv_pkg::OCTAL_COMPLEMENT_OP
			|=> zeroInd == $past(s.zeroAcc))
		else $error("zero indicator wrong");
	prod_clear_a: assert property (
		s.st == ocv_pkg::ST_OCLR |=> s.memWe && s.memWdata[3:0] == 4'h0
			&& s.memAddr >= ocv_pkg::PROD_LOW
			&& s.memAddr <= ocv_pkg::PROD_UNITS)
		else $error("product clear wrong");
	result_flag_a: assert property (
		s.st == ocv_pkg::ST_FLW |=> s.memWdata[ocv_pkg::FLAG_BIT]
			&& s.memAddr == $past(s.minAddr) ##2 !s.busy)
		else $error("result flag wrong");
	quot_store_a: assert property (
		s.st == ocv_pkg::ST_DQW |=> s.memWe && s.memAddr == $past(s.pa)
			&& s.memWdata[ocv_pkg::FLAG_BIT] == $past(s.first))
		else $error("quotient store wrong");
	overflow_set_a: assert property (
		s.st == ocv_pkg::ST_DSUB && s.commit && s.eDone && s.dDone
			&& s.cnt == 4'h7 |=> ovfInd)
		else $error("overflow not set");
	rec_mark_end_a: assert property (
		s.st == ocv_pkg::ST_DNX2 && memRdata[3:0] == 4'hA
			|=> s.st == ocv_pkg::ST_DONE ##1 !busy)
		else $error("record mark missed");
endmodule : ocv_field_unit
`default_nettype wire

// ===== src/ocv_pkg.sv
// Purpose: Shared constants, types and digit helpers for the octal unit
// Assumes: Storage digit is {flag, check, 8, 4, 2, 1}, odd check parity
// Notes:   Register offsets are byte addresses on a 32-bit Wishbone bus
`default_nettype none
package ocv_pkg;
	typedef enum logic [1:0] {
		OCTAL_COMPLEMENT_OP,
		OCTAL_TO_DECIMAL_OP,
		DECIMAL_TO_OCTAL_OP,
		NO_OP
	} ocv_op_t;

	typedef enum logic [4:0] {
		ST_IDLE, ST_WAIT, ST_DONE,
		ST_CPLR, ST_CPLW,
		ST_OCLR, ST_ORDQ, ST_OGOTQ, ST_ORDE, ST_OGOTE, ST_OADD,
		ST_OSCR, ST_OSCG, ST_FLR, ST_FLW,
		ST_DTRY, ST_DRDE, ST_DGOTE, ST_DRDD, ST_DGOTD, ST_DSUB,
		ST_DQW, ST_DNX1, ST_DNX2, ST_DSC1, ST_DSC2
	} ocv_st_t;

	localparam logic [3:0]  REG_CTRL   = 4'h0;
	localparam logic [3:0]  REG_PADDR  = 4'h4;
	localparam logic [3:0]  REG_QADDR  = 4'h8;
	localparam logic [3:0]  REG_STATUS = 4'hC;
	localparam int          CTRL_START = 4;
	localparam int          STAT_BUSY  = 0;
	localparam int          STAT_ZERO  = 1;
	localparam int          STAT_OVF   = 2;
	localparam int          FLAG_BIT   = 5;
	localparam logic [15:0] PROD_LOW   = 16'h0050;
	localparam logic [15:0] PROD_UNITS = 16'h0063;
	localparam logic [3:0]  QUOT_LAST  = 4'h7;
	localparam logic [3:0]  REC_MARK   = 4'hA;
	localparam logic [4:0]  DEC_BASE   = 5'h0A;

	typedef struct packed {
		ocv_st_t     st;
		ocv_st_t     ret;
		ocv_op_t     op;
		logic [15:0] pReg;
		logic [15:0] qReg;
		logic        ack;
		logic [31:0] rdat;
		logic        memReq;
		logic        memWe;
		logic [15:0] memAddr;
		logic [5:0]  memWdata;
		logic [15:0] qa;
		logic [15:0] pa;
		logic [15:0] ta;
		logic [15:0] ea;
		logic [15:0] wa;
		logic [15:0] minAddr;
		logic [3:0]  eDig;
		logic [3:0]  dDig;
		logic [3:0]  cnt;
		logic        dFlag;
		logic        dValid;
		logic        eDone;
		logic        dDone;
		logic        carry;
		logic        commit;
		logic        first;
		logic        qLast;
		logic        zeroAcc;
		logic        zeroInd;
		logic        ovf;
		logic        busy;
	} ocv_core_t;

	localparam ocv_core_t CORE_RESET = '0;

	// Check bit makes the five low bits odd
	function automatic logic [5:0] mkDigit(input logic f,
		input logic [3:0] v);
		return {f, ~^v, v};
	endfunction : mkDigit

	function automatic logic isRecMark(input logic [5:0] d);
		return d[3:0] == REC_MARK;
	endfunction : isRecMark
endpackage : ocv_pkg
`default_nettype wire

// ===== testbench/ocv_store_model.sv
// Purpose: Behavioural digit storage on the far side of the octal unit
// Assumes: Read data holds for two edges after the request is seen
// Notes:   Stale read data is shown inverted so no old value lingers
`default_nettype none
module ocv_store_model (
	input  wire logic        ref_clk,
	input  wire logic        memReq,
	input  wire logic        memWe,
	input  wire logic [15:0] memAddr,
	input  wire logic [5:0]  memWdata,
	output logic      [5:0]  memRdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [5:0] mem [0:1023];
	logic [5:0] rdReg = 6'h00;
	logic [1:0] hold  = 2'h0;
	// Plain always: the bench also preloads mem between operations
	always @(posedge ref_clk) begin
		if (memReq && memWe) begin
			mem[memAddr[9:0]] <= memWdata;
		end
		if (memReq && !memWe) begin
			rdReg <= mem[memAddr[9:0]];
			hold  <= 2'h2;
		end else if (hold != 2'h0) begin
			hold <= hold - 2'h1;
		end
	end
	assign memRdata = (hold != 2'h0) ? rdReg : ~rdReg;
endmodule : ocv_store_model
`default_nettype wire

// ===== testbench/tb_top.sv
// Purpose: Self-checking bench for the octal field unit
// Assumes: Digit values in rows are written as decimal digit patterns
// Notes:   Rows hold ordinary runs; awkward cases follow by hand
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {
		ocv_pkg::ocv_op_t op;
		int               p, q, sN, eU, eN;
		longint           sV, eV;
		logic             zero, ovf;
	} ocv_row_t;
	logic        ref_clk, reset, wbCyc, wbStb, wbWe, wbAck;
	logic        memReq, memWe, zeroInd, ovfInd, busy;
	logic [3:0]  wbAdr, wbSel;
	logic [31:0] wbDat, wbDo, rd;
	logic [15:0] memAddr;
	logic [5:0]  memWdata, memRdata;
	int          err_count = 0;
	int          n_tests   = 0;
	ocv_row_t    r;
	ocv_row_t    rows [9] = '{
		'{ocv_pkg::OCTAL_COMPLEMENT_OP, 520, 600, 5, 520, 5, 89742, 76035, 0, 0},
		'{ocv_pkg::OCTAL_COMPLEMENT_OP, 530, 610, 1, 530, 1, 7, 0, 1, 0},
		'{ocv_pkg::OCTAL_COMPLEMENT_OP, 540, 620, 3, 540, 3, 777, 0, 1, 0},
		'{ocv_pkg::OCTAL_COMPLEMENT_OP, 550, 630, 2, 550, 2, 70, 7, 0, 0},
		'{ocv_pkg::OCTAL_TO_DECIMAL_OP, 399, 650, 4, 99, 4, 2537, 1375, 0, 0},
		'{ocv_pkg::OCTAL_TO_DECIMAL_OP, 799, 660, 5, 99, 5, 77777, 32767, 0, 0},
		'{ocv_pkg::OCTAL_TO_DECIMAL_OP, 399, 670, 4, 99, 4, 2037, 1055, 0, 0},
		'{ocv_pkg::DECIMAL_TO_OCTAL_OP, 500, 386, 5, 505, 6, 99999, 303237, 0, 0},
		'{ocv_pkg::DECIMAL_TO_OCTAL_OP, 560, 397, 2, 561, 2, 64, 0, 0, 1}};

	ocv_field_unit u_dut (.ref_clk(ref_clk), .reset(reset), .wb_cyc_i(wbCyc),
		.wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
		.wb_dat_i(wbDat), .wb_dat_o(wbDo), .wb_ack_o(wbAck), .memReq(memReq),
		.memWe(memWe), .memAddr(memAddr), .memWdata(memWdata),
		.memRdata(memRdata), .zeroInd(zeroInd), .ovfInd(ovfInd), .busy(busy));
	ocv_store_model u_mem (.ref_clk(ref_clk), .memReq(memReq), .memWe(memWe),
		.memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata));

	function automatic logic [5:0] dg(input logic f, input logic [3:0] v);
		return {f, ~^v, v};
	endfunction : dg

	task automatic summarize;
		if (err_count == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : summarize

	task automatic chk32(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk32

	task automatic chkDig(input int a, input logic [5:0] e);
		n_tests++;
		if (u_mem.mem[a] !== e) begin
			err_count++;
			$display("[ERR] %0t at %0d got %h exp %h", $time, a,
				u_mem.mem[a], e);
		end
	endtask : chkDig

	// Leftmost digit of a field carries the flag
	task automatic putNum(input int u, input int n, input longint v);
		for (int i = 0; i < n; i++) begin
			u_mem.mem[u - i] = dg(i == n - 1, 4'(v % 10));
			v = v / 10;
		end
	endtask : putNum

	task automatic chkNum(input int u, input int n, input longint v);
		for (int i = 0; i < n; i++) begin
			chkDig(u - i, dg(i == n - 1, 4'(v % 10)));
			v = v / 10;
		end
	endtask : chkNum

	// Powers of eight downward from units u, record mark to the right
	task automatic putTable(input int u);
		putNum(u, 2, 1);
		putNum(u - 2, 2, 8);
		putNum(u - 4, 2, 64);
		putNum(u - 6, 3, 512);
		putNum(u - 9, 4, 4096);
		putNum(u - 13, 5, 32768);
		u_mem.mem[u + 1] = dg(1'b0, 4'hA);
	endtask : putTable

	// Starts just after an edge; holds the request until ack is sampled
	task automatic wbXfer(input logic we, input logic [3:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe  <= we;
		wbAdr <= a;
		wbDat <= d;
		do begin
			@(posedge ref_clk);
			n++;
		end while (wbAck !== 1'b1 && n < 100);
		if (n == 100) begin
			err_count++;
		end
		q = wbDo;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		wbWe  <= 1'b0;
		@(posedge ref_clk);
	endtask : wbXfer

	task automatic waitIdle;
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 20000) begin
			@(posedge ref_clk);
			n++;
		end
		chk32({31'h0, busy}, 32'h0000_0000);
	endtask : waitIdle

	task automatic runOp(input ocv_pkg::ocv_op_t op, input int p, input int q);
		wbXfer(1'b1, ocv_pkg::REG_PADDR, 32'(p), rd);
		wbXfer(1'b1, ocv_pkg::REG_QADDR, 32'(q), rd);
		wbXfer(1'b1, ocv_pkg::REG_CTRL, 32'h0000_0010 | 32'(op), rd);
		chk32({31'h0, busy}, 32'h0000_0001);
		waitIdle;
	endtask : runOp

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// Cut a hang short; a full run needs far fewer cycles
	initial begin
		repeat (80000) @(posedge ref_clk);
		err_count++;
		summarize;
	end

	initial begin
		reset = 1'b1;
		{wbCyc, wbStb, wbWe} = 3'h0;
		wbAdr = 4'h0;
		wbSel = 4'hF;
		wbDat = 32'h0000_0000;
		for (int a = 0; a < 1024; a++) begin
			u_mem.mem[a] = dg(1'b0, 4'h5);
		end
		putTable(399);
		putTable(799);
		repeat (16) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		chk32({wbAck, memReq, busy, zeroInd, ovfInd}, 32'h0000_0000);
		foreach (rows[i]) begin
			r = rows[i];
			// Garbage in the product area shows a missing clear
			for (int a = 80; a < 100; a++) begin
				u_mem.mem[a] = dg(1'b0, 4'h9);
			end
			for (int a = r.eU - r.eN + 1; a <= r.eU; a++) begin
				u_mem.mem[a] = dg(1'b1, 4'h9);
			end
			// Dividend units at the product units; results fit in 20 places
			putNum(r.op == ocv_pkg::DECIMAL_TO_OCTAL_OP ? 99 : r.q, r.sN, r.sV);
			runOp(r.op, r.p, r.q);
			chkNum(r.eU, r.eN, r.eV);
			chk32({31'h0, ovfInd}, {31'h0, r.ovf});
			if (r.op == ocv_pkg::OCTAL_COMPLEMENT_OP) begin
				chk32({31'h0, zeroInd}, {31'h0, r.zero});
				chkDig(r.eU - r.eN, dg(1'b0, 4'h5));
				chkNum(r.q, r.sN, r.sV);
			end
			if (r.op == ocv_pkg::OCTAL_TO_DECIMAL_OP) begin
				for (int a = 80; a <= 99 - r.eN; a++) begin
					chkDig(a, dg(1'b0, 4'h0));
				end
			end
		end
		wbXfer(1'b0, ocv_pkg::REG_STATUS, 32'h0000_0000, rd);
		chk32(rd, 32'h0000_0004);
		wbXfer(1'b1, ocv_pkg::REG_STATUS, 32'h0000_0004, rd);
		chk32({31'h0, ovfInd}, 32'h0000_0000);
		wbXfer(1'b0, ocv_pkg::REG_QADDR, 32'h0000_0000, rd);
		chk32(rd, 32'h0000_018D);
		wbXfer(1'b0, 4'h2, 32'h0000_0000, rd);
		chk32(rd, 32'h0000_0000);
		wbXfer(1'b1, ocv_pkg::REG_CTRL, 32'h0000_0013, rd);
		repeat (4) @(posedge ref_clk);
		chk32({31'h0, busy}, 32'h0000_0000);
		wbXfer(1'b0, ocv_pkg::REG_CTRL, 32'h0000_0000, rd);
		chk32(rd, 32'h0000_0003);
		// A second start while busy must not disturb the running divide
		for (int a = 500; a < 506; a++) begin
			u_mem.mem[a] = dg(1'b1, 4'h9);
		end
		putNum(99, 5, 99999);
		wbXfer(1'b1, ocv_pkg::REG_PADDR, 32'h0000_01F4, rd);
		wbXfer(1'b1, ocv_pkg::REG_QADDR, 32'h0000_0182, rd);
		wbXfer(1'b1, ocv_pkg::REG_CTRL, 32'h0000_0012, rd);
		wbXfer(1'b1, ocv_pkg::REG_CTRL, 32'h0000_0010, rd);
		waitIdle;
		chkNum(505, 6, 303237);
		// Reset in mid-run leaves everything quiet
		wbXfer(1'b1, ocv_pkg::REG_CTRL, 32'h0000_0011, rd);
		reset <= 1'b1;
		@(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		chk32({wbAck, memReq, busy, ovfInd}, 32'h0000_0000);
		summarize;
	end
endmodule : tb_top
`default_nettype wire
